// ### hw/gcd_core.sv
/*
 * Graphic LCD column driver core: 512x8 display RAM, host parallel
 * port with status, instructions and data, row scan and segment drive.
 * Assumes all inputs synchronous to SYS_CLK_I, line strobe phases
 * many clocks long, and a host that polls status before commands.
 */
// Functional notes
// - status bit 7 shows busy; while busy only status reads act
// - display on drives RAM dots; display off shows unlit everywhere except during RESET_I, which loads level V1
// - status bit 5 carries the display on/off state
// - blank flag reads one when display off, zero when on
// - on/off instruction touches only segment output state, not RAM
// - 6-bit start line register presets row counter while frame_sync high
// - RAM address is 3-bit fixed page plus 6-bit column
// - column loads by instruction, steps after each data access, wraps
// - seg_order_select picks normal or reversed column-to-segment order
// - RAM one gives lit level, zero gives unlit level
// - 6-bit row counter advances on each line_strobe falling edge while frame_sync low
// - row data latched into segment latch on line_strobe rising edge
// - segment level chosen from latched dot and ac_phase, four levels
// - chip reset forces display off and start line to zero
// - status bit 4 set during reset; only status reads accepted
// - page set stays in force for all data accesses until changed
// - data write stores byte at page and column, then steps column
// - first data read after address set returns stale held byte
// - read drives held byte while strobe high; fall reloads and steps
// - host writes captured on strobe falling edge with chip selected
// - select low and read gives status; both low takes instruction
`timescale 1ns/10ps

module gcd_core (
	input  wire logic         SYS_CLK_I,
	input  wire logic         RESET_I,
	input  wire logic         CHIP_RESET_LOW_I,
	input  wire logic         CHIP_SEL_I,
	input  wire logic         STROBE_I,
	input  wire logic         READ_NOT_WRITE_I,
	input  wire logic         DATA_INSTR_SELECT_I,
	input  wire logic [7:0]   HOST_DATA_BUS_I,
	input  wire logic         SEG_ORDER_SELECT_I,
	input  wire logic         FRAME_SYNC_I,
	input  wire logic         LINE_STROBE_I,
	input  wire logic         AC_PHASE_I,
	output logic      [7:0]   HOST_DATA_BUS_O,
	output logic              HOST_DATA_BUS_OE_LOW_O,
	output logic      [127:0] SEGMENT_OUTPUTS_O
);
	// ==========================================================
	// state record
	typedef struct packed {
		gcd_pkg::gcd_state_e_t state;
		logic [gcd_pkg::CNT_W-1:0]  cnt;
		logic                       strobe_d;
		logic                       line_d;
		logic                       disp_on;
		logic [gcd_pkg::LINE_W-1:0] start_line;
		logic [gcd_pkg::LINE_W-1:0] row;
		logic [gcd_pkg::PAGE_W-1:0] page;
		logic [gcd_pkg::COL_W-1:0]  col;
		logic [7:0]                 hold;
		logic [gcd_pkg::NUM_SEG-1:0] seg_latch;
		logic [2*gcd_pkg::NUM_SEG-1:0] seg_out;
		logic [7:0]                 bus_out;
		logic                       bus_oe_n;
	} gcd_reg_t;

	localparam logic [gcd_pkg::CNT_W-1:0] BUSY_CNT =
		gcd_pkg::CNT_W'(gcd_pkg::BUSY_CYCLES);
	localparam logic [gcd_pkg::CNT_W-1:0] INIT_CNT =
		gcd_pkg::CNT_W'(gcd_pkg::INIT_CYCLES);

	localparam gcd_reg_t RESET_VAL = '{
		state:      gcd_pkg::ST_RESET,
		cnt:        INIT_CNT,
		strobe_d:   1'b0,
		line_d:     1'b0,
		disp_on:    1'b0,
		start_line: gcd_pkg::LINE_RESET,
		row:        6'h00,
		page:       3'h0,
		col:        6'h00,
		hold:       8'h00,
		seg_latch:  64'h0,
		seg_out:    128'h0,
		bus_out:    8'h00,
		bus_oe_n:   1'b1
	};

	gcd_reg_t st;
	gcd_reg_t next_st;

	logic [7:0] ram [gcd_pkg::RAM_DEPTH];
	logic                        ram_we;
	logic [gcd_pkg::ADDR_W-1:0]  ram_addr;
	logic [7:0]                  ram_wdata;
	logic [gcd_pkg::NUM_SEG-1:0] row_bits;
	logic [2*gcd_pkg::NUM_SEG-1:0] seg_level;
	logic                        strobe_fall;
	logic                        accept;
	logic                        line_rise;
	logic                        line_fall;
	logic [7:0]                  status;
	logic                        acc_cmd;
	logic                        acc_rd;
	logic                        acc_wr;
	logic                        acc_instr;
	logic                        op_onoff;
	logic                        op_line;
	logic                        op_page;
	logic                        op_col;

	// ==========================================================
	// per-segment readout and drive level
	generate
		for (genvar s = 0; s < gcd_pkg::NUM_SEG; s++) begin : g_seg
			logic [5:0] seg_col;
			logic [7:0] seg_word;
			logic       dot;
			logic [1:0] lvl;
			assign seg_col = SEG_ORDER_SELECT_I ? 6'(s)
				: gcd_pkg::COL_LAST - 6'(s);
			// page from row, bit in byte
			assign seg_word = ram[{st.row[5:3], seg_col}];
			assign row_bits[s] = seg_word[st.row[2:0]];
			assign dot = st.seg_latch[s] & st.disp_on;
			always_comb begin
				if (dot) begin
					lvl = AC_PHASE_I ? gcd_pkg::LVL_V1 : gcd_pkg::LVL_V2;
				end else begin
					lvl = AC_PHASE_I ? gcd_pkg::LVL_V3 : gcd_pkg::LVL_V4;
				end
			end
			// one driver per segment slice
			assign seg_level[2*s +: 2] = lvl;
		end
	endgenerate

	// ==========================================================
	// status byte
	always_comb begin
		status = 8'h00;
		status[gcd_pkg::STAT_BUSY_BIT] = (st.state == gcd_pkg::ST_BUSY);
		status[gcd_pkg::STAT_BLANK_BIT] = ~st.disp_on;
		status[gcd_pkg::STAT_RST_BIT] = (st.state == gcd_pkg::ST_RESET);
	end

	assign strobe_fall = st.strobe_d & ~STROBE_I;
	assign line_rise   = ~st.line_d & LINE_STROBE_I;
	assign line_fall   = st.line_d & ~LINE_STROBE_I;
	assign accept = strobe_fall & CHIP_SEL_I
		& (st.state == gcd_pkg::ST_IDLE);

	// ==========================================================
	// access decode
	// select and direction
	assign acc_cmd   = accept & (DATA_INSTR_SELECT_I | ~READ_NOT_WRITE_I);
	assign acc_rd    = acc_cmd & DATA_INSTR_SELECT_I & READ_NOT_WRITE_I;
	assign acc_wr    = acc_cmd & DATA_INSTR_SELECT_I & ~READ_NOT_WRITE_I;
	assign acc_instr = acc_cmd & ~DATA_INSTR_SELECT_I;
	assign op_onoff  = (HOST_DATA_BUS_I & gcd_pkg::OP_ONOFF_MASK)
		== gcd_pkg::OP_ONOFF_VAL;
	assign op_line   = (HOST_DATA_BUS_I & gcd_pkg::OP_LINE_MASK)
		== gcd_pkg::OP_LINE_VAL;
	assign op_page   = (HOST_DATA_BUS_I & gcd_pkg::OP_PAGE_MASK)
		== gcd_pkg::OP_PAGE_VAL;
	assign op_col    = (HOST_DATA_BUS_I & gcd_pkg::OP_COL_MASK)
		== gcd_pkg::OP_COL_VAL;

	// ==========================================================
	// next state
	always_comb begin
		next_st   = st;
		ram_we    = 1'b0;
		ram_addr  = {st.page, st.col};
		ram_wdata = HOST_DATA_BUS_I;
		next_st.strobe_d = STROBE_I;
		next_st.line_d   = LINE_STROBE_I;

		// busy and init countdown
		case (st.state)
			gcd_pkg::ST_RESET,
			gcd_pkg::ST_BUSY: begin
				if (st.cnt <= 6'h01) begin
					next_st.state = gcd_pkg::ST_IDLE;
					next_st.cnt   = 6'h00;
				end else begin
					next_st.cnt = st.cnt - 6'h01;
				end
			end
			gcd_pkg::ST_IDLE: begin
				next_st.cnt = 6'h00;
			end
			default: begin
				next_st.state = gcd_pkg::ST_RESET;
				next_st.cnt   = INIT_CNT;
			end
		endcase

		// host accesses other than status read
		if (acc_cmd) begin
			next_st.state = gcd_pkg::ST_BUSY;
			next_st.cnt   = BUSY_CNT;
			if (!acc_instr) begin
				next_st.col = (st.col == gcd_pkg::COL_LAST) ? 6'h00
					: st.col + 6'h01;
				if (acc_rd) begin
					next_st.hold = ram[{st.page, st.col}];
				end else begin
					ram_we = acc_wr;
				end
			end else begin
				if (op_onoff) begin
					next_st.disp_on = HOST_DATA_BUS_I[0];
				end else if (op_line) begin
					next_st.start_line = HOST_DATA_BUS_I[5:0];
				end else if (op_page) begin
					next_st.page = HOST_DATA_BUS_I[2:0];
				end else if (op_col) begin
					next_st.col = HOST_DATA_BUS_I[5:0];
				end
			end
		end

		// stays in reset, then init time
		if (!CHIP_RESET_LOW_I) begin
			next_st.state      = gcd_pkg::ST_RESET;
			next_st.cnt        = INIT_CNT;
			next_st.disp_on    = 1'b0;
			next_st.start_line = gcd_pkg::LINE_RESET;
			ram_we             = 1'b0;
		end

		// ==========================================================
		// row scan
		if (FRAME_SYNC_I) begin
			next_st.row = st.start_line;
		end else if (line_fall) begin
			next_st.row = st.row + 6'h01;
		end
		if (line_rise) begin
			next_st.seg_latch = row_bits;
		end
		next_st.seg_out = seg_level;

		// ==========================================================
		// host read port
		// drive hold while strobe high
		next_st.bus_oe_n = ~(CHIP_SEL_I & STROBE_I & READ_NOT_WRITE_I);
		next_st.bus_out  = DATA_INSTR_SELECT_I ? st.hold : status;
	end

	// ==========================================================
	// registers
	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			st <= RESET_VAL;
		end else begin
			st <= next_st;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (ram_we) begin
			ram[ram_addr] <= ram_wdata;
		end
	end

	assign HOST_DATA_BUS_O        = st.bus_out;
	assign HOST_DATA_BUS_OE_LOW_O = st.bus_oe_n;
	assign SEGMENT_OUTPUTS_O      = st.seg_out;
endmodule : gcd_core

// ### hw/gcd_pkg.sv
/*
 * Constants for the graphic column driver core: status byte layout,
 * instruction encodings, drive level codes, timing counts.
 * Assumes a single 50 MHz system clock.
 */
package gcd_pkg;
	// ==========================================================
	// clock and timing
	localparam int CLK_PERIOD_NS  = 20;
	localparam int BUSY_TIME_NS   = 100;
	localparam int INIT_TIME_NS   = 1000;
	localparam int BUSY_CYCLES    =
		(BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INIT_CYCLES    =
		(INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W          = 6;

	// ==========================================================
	// geometry
	localparam int NUM_SEG        = 64;
	localparam int LINE_W         = 6;
	localparam int PAGE_W         = 3;
	localparam int COL_W          = 6;
	localparam int ADDR_W         = 9;
	localparam int RAM_DEPTH      = 512;
	localparam logic [5:0] COL_LAST   = 6'h3f;
	localparam logic [5:0] LINE_RESET = 6'h00;

	// ==========================================================
	// status byte bit positions
	localparam int STAT_BUSY_BIT  = 7;
	localparam int STAT_BLANK_BIT = 5;
	localparam int STAT_RST_BIT   = 4;

	// ==========================================================
	// instruction decode: value under mask
	localparam logic [7:0] OP_ONOFF_MASK = 8'hfe;
	localparam logic [7:0] OP_ONOFF_VAL  = 8'h3e;
	localparam logic [7:0] OP_LINE_MASK  = 8'hc0;
	localparam logic [7:0] OP_LINE_VAL   = 8'hc0;
	localparam logic [7:0] OP_PAGE_MASK  = 8'hf8;
	localparam logic [7:0] OP_PAGE_VAL   = 8'hb8;
	localparam logic [7:0] OP_COL_MASK   = 8'hc0;
	localparam logic [7:0] OP_COL_VAL    = 8'h40;

	// ==========================================================
	// segment drive level codes
	localparam logic [1:0] LVL_V1 = 2'h0;
	localparam logic [1:0] LVL_V2 = 2'h1;
	localparam logic [1:0] LVL_V3 = 2'h2;
	localparam logic [1:0] LVL_V4 = 2'h3;

	// ==========================================================
	// control states
	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_IDLE  = 2'b01,
		ST_BUSY  = 2'b10
	} gcd_state_e_t;
endpackage : gcd_pkg

// ### bench/gcd_core_asserts.sv
/* checker of host port status and segment blanking for gcd_core.
   assumes one clock, bound to every gcd_core instance. */
`timescale 1ns/10ps
module gcd_core_asserts (
	input wire logic         SYS_CLK_I,
	input wire logic         RESET_I,
	input wire logic         CHIP_RESET_LOW_I,
	input wire logic         CHIP_SEL_I,
	input wire logic         STROBE_I,
	input wire logic         READ_NOT_WRITE_I,
	input wire logic         DATA_INSTR_SELECT_I,
	input wire logic         AC_PHASE_I,
	input wire logic [7:0]   HOST_DATA_BUS_O,
	input wire logic         HOST_DATA_BUS_OE_LOW_O,
	input wire logic [127:0] SEGMENT_OUTPUTS_O
);
	// ==========================================================
	// helpers
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (RESET_I);
	localparam logic [127:0] HI = {64{2'b10}};
	logic [5:0] cnt;
	logic [5:0] next_cnt;
	logic       rd;
	assign rd = STROBE_I && CHIP_SEL_I && READ_NOT_WRITE_I
		&& DATA_INSTR_SELECT_I;
	always_comb next_cnt = !CHIP_RESET_LOW_I ? 6'h00
		: cnt + {5'h00, cnt != 6'h3f};
	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) cnt <= 6'h00;
		else cnt <= next_cnt;
	end
	sequence s_stat;
		!HOST_DATA_BUS_OE_LOW_O && $past(!DATA_INSTR_SELECT_I);
	endsequence
	sequence s_in_rst;
		s_stat ##0 $past(!CHIP_RESET_LOW_I, 2);
	endsequence
	// ==========================================================
	// properties
	property p_stat_zero;
		s_stat |-> (HOST_DATA_BUS_O & 8'h4f) == 8'h00;
	endproperty
	property p_oe;
		HOST_DATA_BUS_OE_LOW_O
			== !$past(STROBE_I && CHIP_SEL_I && READ_NOT_WRITE_I);
	endproperty
	property p_rst_bit;
		s_in_rst |-> HOST_DATA_BUS_O[4];
	endproperty
	property p_rst_off;
		s_in_rst |-> HOST_DATA_BUS_O[5];
	endproperty
	property p_off_unlit;
		$past(!CHIP_RESET_LOW_I, 2) |-> (SEGMENT_OUTPUTS_O & HI) == HI;
	endproperty
	property p_off_ac;
		$past(!CHIP_RESET_LOW_I, 2)
			|-> SEGMENT_OUTPUTS_O[1:0] == {1'b1, !$past(AC_PHASE_I)};
	endproperty
	property p_rd_hold;
		$past(rd) && $past(rd, 2) |-> $stable(HOST_DATA_BUS_O);
	endproperty
	property p_init;
		s_stat ##0 !HOST_DATA_BUS_O[4] |-> cnt >= 6'd48;
	endproperty
	a_stat_zero: assert property (p_stat_zero)
		else $error("status spare bits not zero");
	a_oe: assert property (p_oe)
		else $error("bus drive not tied to read strobe");
	a_rst_bit: assert property (p_rst_bit)
		else $error("reset bit clear during chip reset");
	a_rst_off: assert property (p_rst_off)
		else $error("display not off during chip reset");
	a_off_unlit: assert property (p_off_unlit)
		else $error("segment lit while display off");
	a_off_ac: assert property (p_off_ac)
		else $error("unlit level does not follow ac phase");
	a_rd_hold: assert property (p_rd_hold)
		else $error("read byte changed while strobe high");
	a_init: assert property (p_init)
		else $error("reset bit cleared too early");
endmodule : gcd_core_asserts

bind gcd_core gcd_core_asserts u_gcd_core_asserts (
	.SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I),
	.CHIP_RESET_LOW_I(CHIP_RESET_LOW_I), .CHIP_SEL_I(CHIP_SEL_I),
	.STROBE_I(STROBE_I), .READ_NOT_WRITE_I(READ_NOT_WRITE_I),
	.DATA_INSTR_SELECT_I(DATA_INSTR_SELECT_I), .AC_PHASE_I(AC_PHASE_I),
	.HOST_DATA_BUS_O(HOST_DATA_BUS_O),
	.HOST_DATA_BUS_OE_LOW_O(HOST_DATA_BUS_OE_LOW_O),
	.SEGMENT_OUTPUTS_O(SEGMENT_OUTPUTS_O));

// ### bench/gcd_panel_model.sv
/* common driver model: frame sync, line strobe and ac phase.
   assumes the bench calls its tasks; outputs move on rising edges. */
`timescale 1ns/10ps
module gcd_panel_model (
	input  wire logic clk_i,
	output logic      frame_sync_o,
	output logic      line_strobe_o,
	output logic      ac_phase_o
);
	initial begin
		frame_sync_o = 1'b0;
		line_strobe_o = 1'b0;
		ac_phase_o = 1'b0;
	end
	// ==========================================================
	// frame and line phases
	// frame preset pulse
	task automatic frame();
		@(posedge clk_i) frame_sync_o <= 1'b1;
		repeat (3) @(posedge clk_i);
		frame_sync_o <= 1'b0;
	endtask : frame
	task automatic rise();
		@(posedge clk_i) line_strobe_o <= 1'b1;
		repeat (3) @(posedge clk_i);
	endtask : rise
	task automatic fall();
		@(posedge clk_i) line_strobe_o <= 1'b0;
		ac_phase_o <= ~ac_phase_o;
		repeat (3) @(posedge clk_i);
	endtask : fall
endmodule : gcd_panel_model

// ### bench/gcd_core_tb_top.sv
/* self-checking bench for gcd_core with host accesses and panel scan.
   assumes gcd_pkg timing: 5 clock busy, 50 clock init. */
`timescale 1ns/10ps
module gcd_core_tb_top;
	logic         clk, rst, crl, cs, stb, rw, di, fs, ls, ac, oe_low;
	logic [7:0]   dbi, dbo, rd;
	logic [127:0] seg;
	logic [7:0]   mem [64];
	logic [31:0]  x = 32'h1189;
	int           errors = 0;
	int           n_checks = 0;
	gcd_core u_gcd_core (.SYS_CLK_I(clk), .RESET_I(rst),
		.CHIP_RESET_LOW_I(crl), .CHIP_SEL_I(cs), .STROBE_I(stb),
		.READ_NOT_WRITE_I(rw), .DATA_INSTR_SELECT_I(di),
		.HOST_DATA_BUS_I(dbi), .SEG_ORDER_SELECT_I(1'b1),
		.FRAME_SYNC_I(fs), .LINE_STROBE_I(ls), .AC_PHASE_I(ac),
		.HOST_DATA_BUS_O(dbo), .HOST_DATA_BUS_OE_LOW_O(oe_low),
		.SEGMENT_OUTPUTS_O(seg));
	gcd_panel_model u_gcd_panel_model (.clk_i(clk), .frame_sync_o(fs),
		.line_strobe_o(ls), .ac_phase_o(ac));
	// ==========================================================
	// helpers
	function automatic logic [31:0] lfsr(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	function automatic logic [127:0] seg_exp(int r, logic a, logic on);
		logic [127:0] v;
		for (int s = 0; s < 64; s++) v[2*s +: 2] = {~(on & mem[s][r]), ~a};
		return v;
	endfunction : seg_exp
	task automatic chk(logic [127:0] e, logic [127:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk
	task automatic acc(logic d, logic w, logic [7:0] v, int gap);
		@(posedge clk);
		di <= d;
		rw <= ~w;
		dbi <= v;
		stb <= 1'b1;
		@(posedge clk);
		@(negedge clk) rd = dbo;
		@(posedge clk) stb <= 1'b0;
		repeat (gap) @(posedge clk);
	endtask : acc
	// reset and busy bits both zero
	task automatic ready();
		for (int i = 0; i < 80; i++) begin
			acc(0, 0, 8'h00, 0);
			if ((rd & 8'h90) === 8'h00) return;
		end
		chk(8'h00, rd & 8'h90);
	endtask : ready
	task automatic report_and_stop();
		$display("errors=%0d n_checks=%0d", errors, n_checks);
		if (errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	// ==========================================================
	// clock, watchdog, tests
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#200000;
		errors++;
		report_and_stop();
	end
	initial begin
		rst = 1; crl = 1; cs = 1; stb = 0; rw = 0; di = 0; dbi = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		acc(0, 0, 8'h00, 0);
		chk(8'h30, rd);
		ready();
		chk(8'h20, rd);
		acc(0, 1, 8'h3f, 0);
		acc(0, 0, 8'h00, 0);
		chk(8'h80, rd);
		ready();
		chk(8'h00, rd);
		acc(0, 1, 8'hb8, 5);
		acc(0, 1, 8'h40, 5);
		for (int c = 0; c < 64; c++) begin
			x = lfsr(x);
			mem[c] = x[7:0];
			acc(1, 1, mem[c], 5);
		end
		acc(0, 1, 8'h7e, 5);
		acc(1, 1, ~mem[0], 0);
		acc(1, 1, mem[0], 5);
		mem[62] = ~mem[0];
		acc(0, 1, 8'h7e, 5);
		acc(1, 0, 8'h00, 5);
		for (int c = 62; c < 65; c++) begin
			acc(1, 0, 8'h00, 5);
			chk(mem[c % 64], rd);
		end
		acc(0, 1, 8'hbd, 5);
		acc(0, 1, 8'h40, 5);
		acc(1, 1, 8'ha5, 5);
		acc(0, 1, 8'h40, 5);
		acc(1, 0, 8'h00, 5);
		acc(1, 0, 8'h00, 5);
		chk(8'ha5, rd);
		acc(0, 1, 8'hc5, 5);
		u_gcd_panel_model.frame();
		for (int k = 5; k < 8; k++) begin
			u_gcd_panel_model.rise();
			chk(seg_exp(k, ac, 1), seg);
			u_gcd_panel_model.fall();
		end
		acc(0, 1, 8'h3e, 5);
		chk(seg_exp(7, ac, 0), seg);
		acc(0, 1, 8'h3f, 5);
		chk(seg_exp(7, ac, 1), seg);
		@(posedge clk) crl <= 1'b0;
		acc(0, 0, 8'h00, 0);
		crl <= 1'b1;
		chk(8'h30, rd);
		ready();
		acc(0, 1, 8'h3f, 5);
		u_gcd_panel_model.frame();
		u_gcd_panel_model.rise();
		chk(seg_exp(0, ac, 1), seg);
		u_gcd_panel_model.fall();
		acc(0, 1, 8'hb8, 5);
		acc(0, 1, 8'h41, 5);
		acc(1, 0, 8'h00, 5);
		acc(1, 0, 8'h00, 5);
		chk(mem[1], rd);
		report_and_stop();
	end
endmodule : gcd_core_tb_top
